// ---- irq_router_pkg.sv ----
package irq_router_pkg;

  // ***************************************************************
  // vector layout
  // ***************************************************************
  localparam int NUM_VECTORS      = 24;
  localparam int NUM_PRIO_LEVELS  = 4;
  localparam int PRIO_WIDTH       = 2;
  localparam int NUM_NODES        = 23;
  localparam int VEC_GPT_ONE      = 0;
  localparam int VEC_GPT_TWO      = 1;
  localparam int VEC_MEAS         = 2;
  localparam int VEC_ADC_TEN      = 3;
  localparam int VEC_CCU_BASE     = 4;
  localparam int NUM_CCU_NODES    = 4;
  localparam int VEC_SSC_ONE      = 8;
  localparam int VEC_SSC_TWO      = 9;
  localparam int VEC_SERIAL_ONE   = 10;
  localparam int VEC_SERIAL_TWO   = 11;
  localparam int VEC_EXT_ZERO     = 12;
  localparam int VEC_EXT_ONE      = 13;
  localparam int VEC_WAKEUP       = 14;
  localparam int VEC_DIVIDER      = 15;
  localparam int VEC_RESERVED     = 16;
  localparam int VEC_CHARGE_PUMP  = 17;
  localparam int VEC_BRIDGE       = 18;
  localparam int VEC_HIGH_SIDE    = 19;
  localparam int VEC_CURRENT      = 20;
  localparam int VEC_DIFF         = 21;
  localparam int VEC_MONITOR      = 22;
  localparam int VEC_PORT_TWO     = 23;
  localparam int FAIL_ADDR_WIDTH  = 16;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [23:0] VECTORS_RESET  = 24'h000000;
  localparam logic [47:0] PRIO_RESET     = 48'h000000000000;
  localparam logic [15:0] FAIL_ADDR_RESET = 16'h0000;

  // ***************************************************************
  // grouped request carriers
  // ***************************************************************
  typedef struct packed {
    logic receive;
    logic transmit;
    logic error;
  } ssc_req_t;

  typedef struct packed {
    logic receive;
    logic transmit;
  } uart_req_t;

  typedef struct packed {
    logic watchdog_overflow;
    logic meas_clock_watchdog;
    logic pll_lock_loss;
    logic overtemperature;
    logic oscillator_watchdog;
    logic flash_map_error;
    logic ram_ecc_uncorrectable;
    logic flash_ecc_uncorrectable;
    logic supply_prewarning;
    logic stack_overflow;
  } nmi_req_t;

endpackage

// ---- interrupt_request_router.sv ----
`timescale 1ns/10ps
// Overview of operation
// - drive 24 vector lines, each with a 2-bit level among 4 priorities
// - accept 23 peripheral node requests and route them onto vectors
// - single-source peripherals get a dedicated vector, except those ored onto vectors 2, 10, 11 and 12
// - vector 10 ors serial one rx/tx, timer 2, lin sync and lin
// - vector 11 ors serial two rx/tx, timer 21 and external irq two
// - vector 12 ors external irq zero and wake-up; 13 is irq one
// - gp timers on 0 and 1, measurement/8-bit/bandgap on 2, adc on 3
// - capture compare nodes 0..3 drive vectors 4..7
// - sync serial rx, tx, error ored: channel one 8, channel two 9
// - wake-up event raises vector 14, divider request raises 15
// - vector 16 never asserts; 17 charge pump, 18 bridge, 19 high side
// - 20 current sense, 21 differential, 22 monitor, 23 analog port
// - watchdog, clock, pll, temperature, oscillator, map errors raise nmi
// - uncorrectable ram or flash ecc error raises nmi
// - flash double-bit error raises nmi and keeps its failing address
// - supply prewarning and stack overflow each raise nmi
module interrupt_request_router #(
  parameter int ADDR_WIDTH = irq_router_pkg::FAIL_ADDR_WIDTH
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       reset_in,
  input  wire logic                       gp_timer_block_one_in,
  input  wire logic                       gp_timer_block_two_in,
  input  wire logic                       measurement_unit_req_in,
  input  wire logic                       eight_bit_converter_req_in,
  input  wire logic                       bandgap_req_in,
  input  wire logic                       ten_bit_converter_req_in,
  input  wire logic [3:0]                 capture_compare_unit_in,
  input  wire irq_router_pkg::ssc_req_t   sync_serial_one_in,
  input  wire irq_router_pkg::ssc_req_t   sync_serial_two_in,
  input  wire irq_router_pkg::uart_req_t  serial_port_one_in,
  input  wire logic                       timer_two_req_in,
  input  wire logic                       lin_sync_req_in,
  input  wire logic                       lin_req_in,
  input  wire irq_router_pkg::uart_req_t  serial_port_two_in,
  input  wire logic                       timer_twenty_one_req_in,
  input  wire logic                       external_irq_zero_in,
  input  wire logic                       external_irq_one_in,
  input  wire logic                       external_irq_two_in,
  input  wire logic                       wakeup_req_in,
  input  wire logic                       divider_req_in,
  input  wire logic                       charge_pump_req_in,
  input  wire logic                       bridge_driver_req_in,
  input  wire logic                       high_side_switch_req_in,
  input  wire logic                       current_sense_req_in,
  input  wire logic                       differential_unit_req_in,
  input  wire logic                       monitor_input_req_in,
  input  wire logic                       analog_port_req_in,
  input  wire logic [47:0]                vector_priority_in,
  input  wire irq_router_pkg::nmi_req_t   nmi_sources_in,
  input  wire logic [ADDR_WIDTH-1:0]      flash_fail_addr_in,
  output logic [23:0]                     vector_req_out,
  output logic [47:0]                     vector_priority_out,
  output logic                            nmi_req_out,
  output logic [ADDR_WIDTH-1:0]           flash_fail_addr_out,
  output logic                            flash_fail_valid_out
);

  // ***************************************************************
  // state and source tables
  // ***************************************************************
  logic [23:0]           vectors;
  logic [23:0]           next_vectors;
  logic [47:0]           prio;
  logic [47:0]           next_prio;
  logic [23:0][4:0]      line_src;
  logic [9:0]            nmi_terms;
  logic                  nmi;
  logic                  next_nmi;
  logic [ADDR_WIDTH-1:0] fail_addr;
  logic [ADDR_WIDTH-1:0] next_fail_addr;
  logic                  fail_valid;
  logic                  next_fail_valid;

  // ***************************************************************
  // vector gathering
  // ***************************************************************
  // one slot per contributing source; a line is the or of its slots
  always_comb begin
    line_src = {24{5'h00}};
    // levels are only passed through; the core arbitrates among them
    next_prio = vector_priority_in;

    // ***************************************************************
    // timers
    // ***************************************************************
    // each timer block owns its line
    line_src[irq_router_pkg::VEC_GPT_ONE][0] =
      gp_timer_block_one_in;

    line_src[irq_router_pkg::VEC_GPT_TWO][0] =
      gp_timer_block_two_in;

    // ***************************************************************
    // converters
    // ***************************************************************
    line_src[irq_router_pkg::VEC_MEAS][0] =
      measurement_unit_req_in;
    line_src[irq_router_pkg::VEC_MEAS][1] =
      eight_bit_converter_req_in;
    line_src[irq_router_pkg::VEC_MEAS][2] =
      bandgap_req_in;

    line_src[irq_router_pkg::VEC_ADC_TEN][0] =
      ten_bit_converter_req_in;

    // ***************************************************************
    // capture compare
    // ***************************************************************
    // nodes map one to one, no sharing
    for (int i = 0; i < irq_router_pkg::NUM_CCU_NODES; i++) begin
      line_src[irq_router_pkg::VEC_CCU_BASE + i][0] =
        capture_compare_unit_in[i];
    end

    // ***************************************************************
    // synchronous serial channels
    // ***************************************************************
    line_src[irq_router_pkg::VEC_SSC_ONE][0] =
      sync_serial_one_in.receive;
    line_src[irq_router_pkg::VEC_SSC_ONE][1] =
      sync_serial_one_in.transmit;
    line_src[irq_router_pkg::VEC_SSC_ONE][2] =
      sync_serial_one_in.error;

    line_src[irq_router_pkg::VEC_SSC_TWO][0] =
      sync_serial_two_in.receive;
    line_src[irq_router_pkg::VEC_SSC_TWO][1] =
      sync_serial_two_in.transmit;
    line_src[irq_router_pkg::VEC_SSC_TWO][2] =
      sync_serial_two_in.error;

    // ***************************************************************
    // serial ports and their companions
    // ***************************************************************
    // shared line: software polls each source's own flag to tell them apart
    line_src[irq_router_pkg::VEC_SERIAL_ONE][0] =
      serial_port_one_in.receive;
    line_src[irq_router_pkg::VEC_SERIAL_ONE][1] =
      serial_port_one_in.transmit;
    line_src[irq_router_pkg::VEC_SERIAL_ONE][2] =
      timer_two_req_in;
    line_src[irq_router_pkg::VEC_SERIAL_ONE][3] =
      lin_sync_req_in;
    line_src[irq_router_pkg::VEC_SERIAL_ONE][4] =
      lin_req_in;

    line_src[irq_router_pkg::VEC_SERIAL_TWO][0] =
      serial_port_two_in.receive;
    line_src[irq_router_pkg::VEC_SERIAL_TWO][1] =
      serial_port_two_in.transmit;
    line_src[irq_router_pkg::VEC_SERIAL_TWO][2] =
      timer_twenty_one_req_in;
    line_src[irq_router_pkg::VEC_SERIAL_TWO][3] =
      external_irq_two_in;

    // ***************************************************************
    // external requests, wake-up and divider
    // ***************************************************************
    // wake-up also lands on its own line; software sees both
    line_src[irq_router_pkg::VEC_EXT_ZERO][0] =
      external_irq_zero_in;
    line_src[irq_router_pkg::VEC_EXT_ZERO][1] =
      wakeup_req_in;

    line_src[irq_router_pkg::VEC_EXT_ONE][0] =
      external_irq_one_in;

    line_src[irq_router_pkg::VEC_WAKEUP][0] =
      wakeup_req_in;

    line_src[irq_router_pkg::VEC_DIVIDER][0] =
      divider_req_in;

    // ***************************************************************
    // power stage
    // ***************************************************************
    // power stage faults must not wait behind shared lines
    line_src[irq_router_pkg::VEC_CHARGE_PUMP][0] =
      charge_pump_req_in;

    line_src[irq_router_pkg::VEC_BRIDGE][0] =
      bridge_driver_req_in;

    line_src[irq_router_pkg::VEC_HIGH_SIDE][0] =
      high_side_switch_req_in;

    // ***************************************************************
    // analog front end
    // ***************************************************************
    line_src[irq_router_pkg::VEC_CURRENT][0] =
      current_sense_req_in;

    line_src[irq_router_pkg::VEC_DIFF][0] =
      differential_unit_req_in;

    line_src[irq_router_pkg::VEC_MONITOR][0] =
      monitor_input_req_in;

    line_src[irq_router_pkg::VEC_PORT_TWO][0] =
      analog_port_req_in;

    // ***************************************************************
    // line merge
    // ***************************************************************
    for (int v = 0; v < irq_router_pkg::NUM_VECTORS; v++) begin
      next_vectors[v] = |line_src[v];
    end
    // spare line held low so software never sees a phantom vector
    next_vectors[irq_router_pkg::VEC_RESERVED] = 1'b0;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      vectors <= irq_router_pkg::VECTORS_RESET;
      prio    <= irq_router_pkg::PRIO_RESET;
    end else begin
      vectors <= next_vectors;
      prio    <= next_prio;
    end
  end

  // ***************************************************************
  // non-maskable merge and failing address capture
  // ***************************************************************
  always_comb begin
    nmi_terms = 10'h000;

    // ***************************************************************
    // clock, watchdog, temperature and map events
    // ***************************************************************
    nmi_terms[0] =
      nmi_sources_in.watchdog_overflow;

    nmi_terms[1] =
      nmi_sources_in.meas_clock_watchdog;

    nmi_terms[2] =
      nmi_sources_in.pll_lock_loss;

    nmi_terms[3] =
      nmi_sources_in.overtemperature;

    nmi_terms[4] =
      nmi_sources_in.oscillator_watchdog;

    nmi_terms[5] =
      nmi_sources_in.flash_map_error;

    // ***************************************************************
    // memory errors
    // ***************************************************************
    // single-bit errors are corrected upstream and never get here
    nmi_terms[6] =
      nmi_sources_in.ram_ecc_uncorrectable;

    nmi_terms[7] =
      nmi_sources_in.flash_ecc_uncorrectable;

    // ***************************************************************
    // supply and stack
    // ***************************************************************
    nmi_terms[8] =
      nmi_sources_in.supply_prewarning;

    nmi_terms[9] =
      nmi_sources_in.stack_overflow;

    next_nmi = |nmi_terms;

    next_fail_addr  = fail_addr;
    next_fail_valid = fail_valid;
    // address of the latest double-bit error wins; older one is lost
    if (nmi_sources_in.flash_ecc_uncorrectable) begin
      next_fail_addr  = flash_fail_addr_in;
      next_fail_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      nmi        <= 1'b0;
      fail_addr  <= irq_router_pkg::FAIL_ADDR_RESET[ADDR_WIDTH-1:0];
      fail_valid <= 1'b0;
    end else begin
      nmi        <= next_nmi;
      fail_addr  <= next_fail_addr;
      fail_valid <= next_fail_valid;
    end
  end

  assign vector_req_out       = vectors;
  assign vector_priority_out  = prio;
  assign nmi_req_out          = nmi;
  assign flash_fail_addr_out  = fail_addr;
  assign flash_fail_valid_out = fail_valid;

endmodule // interrupt_request_router

// ---- core_irq_model.sv ----
`timescale 1ns/10ps
module core_irq_model (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic [23:0] vector_req_in,
  input  wire logic        nmi_req_in,
  output logic      [23:0] pending_out,
  output logic             nmi_seen_out
);
  // ****************************************
  // fast core: takes the lowest pending line each cycle
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    pending_out <= reset_in ? 24'h000000 :
      vector_req_in | (pending_out & (pending_out - 24'h000001));
    nmi_seen_out <= !reset_in && (nmi_seen_out || nmi_req_in);
  end
endmodule // core_irq_model

// ---- interrupt_request_router_monitor.sv ----
`timescale 1ns/10ps
module interrupt_request_router_monitor #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic                     sys_clk_in,
  input wire logic                     reset_in,
  input wire logic                     wakeup_req_in,
  input wire logic                     external_irq_zero_in,
  input wire logic                     external_irq_one_in,
  input wire logic [47:0]              vector_priority_in,
  input wire irq_router_pkg::nmi_req_t nmi_sources_in,
  input wire logic [ADDR_WIDTH-1:0]    flash_fail_addr_in,
  input wire logic [23:0]              vector_req_out,
  input wire logic [47:0]              vector_priority_out,
  input wire logic                     nmi_req_out,
  input wire logic [ADDR_WIDTH-1:0]    flash_fail_addr_out,
  input wire logic                     flash_fail_valid_out
);
  // ****************************************
  // checks
  // ****************************************
  logic [1:0] up;
  // past values from reset time are not trusted
  always_ff @(posedge sys_clk_in)
    up <= reset_in ? 2'h0 : (up == 2'h3 ? up : up + 2'h1);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  property p_rsvd; vector_req_out[16] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("line 16 set");
  property p_wake; up == 2'h3 |-> vector_req_out[14] ==
    $past(wakeup_req_in); endproperty
  a_wake: assert property (p_wake) else $error("line 14 bad");
  property p_ext0; up == 2'h3 |-> vector_req_out[12] ==
    $past(external_irq_zero_in | wakeup_req_in); endproperty
  a_ext0: assert property (p_ext0) else $error("line 12 bad");
  property p_ext1; up == 2'h3 |-> vector_req_out[13] ==
    $past(external_irq_one_in); endproperty
  a_ext1: assert property (p_ext1) else $error("line 13 bad");
  property p_prio; up == 2'h3 |-> vector_priority_out ==
    $past(vector_priority_in); endproperty
  a_prio: assert property (p_prio) else $error("level bad");
  property p_nmi; up == 2'h3 |-> nmi_req_out ==
    $past(|nmi_sources_in); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi bad");
  property p_fail; up == 2'h3 && nmi_sources_in.flash_ecc_uncorrectable
    |=> flash_fail_valid_out && nmi_req_out &&
    flash_fail_addr_out == $past(flash_fail_addr_in); endproperty
  a_fail: assert property (p_fail) else $error("fail addr bad");
  property p_keep; flash_fail_valid_out |=> flash_fail_valid_out; endproperty
  a_keep: assert property (p_keep) else $error("valid lost");
  c_nmi: cover property ($rose(nmi_req_out));
  c_fail: cover property ($rose(flash_fail_valid_out));
  c_wake: cover property (vector_req_out[12] && vector_req_out[14]);
endmodule // interrupt_request_router_monitor
bind interrupt_request_router interrupt_request_router_monitor #(
  .ADDR_WIDTH(ADDR_WIDTH)) u_monitor (.sys_clk_in, .reset_in,
  .wakeup_req_in, .external_irq_zero_in, .external_irq_one_in,
  .vector_priority_in, .nmi_sources_in, .flash_fail_addr_in,
  .vector_req_out, .vector_priority_out, .nmi_req_out,
  .flash_fail_addr_out, .flash_fail_valid_out);

// ---- interrupt_request_router_test.sv ----
`timescale 1ns/10ps
module interrupt_request_router_test;
  // ****************************************
  // stimulus, expectations, run
  // ****************************************
  logic        sys_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [45:0] s = 46'h0;
  logic [47:0] prio = 48'h0;
  logic [15:0] addr = 16'h0;
  logic [15:0] e_addr = 16'h0;
  logic        e_valid = 1'b0;
  logic [23:0] vec;
  logic [23:0] pending;
  logic [47:0] prio_o;
  logic [15:0] faddr;
  logic        nmi;
  logic        fvalid;
  logic        nmi_seen;
  integer      seed = 65777;
  int          num_errors = 0;
  int          checks_done = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  interrupt_request_router #(.ADDR_WIDTH(16)) u_interrupt_request_router (
    .sys_clk_in, .reset_in, .gp_timer_block_one_in(s[0]),
    .gp_timer_block_two_in(s[1]), .measurement_unit_req_in(s[2]),
    .eight_bit_converter_req_in(s[3]), .bandgap_req_in(s[4]),
    .ten_bit_converter_req_in(s[5]), .capture_compare_unit_in(s[9:6]),
    .sync_serial_one_in(s[12:10]), .sync_serial_two_in(s[15:13]),
    .serial_port_one_in(s[17:16]), .timer_two_req_in(s[18]),
    .lin_sync_req_in(s[19]), .lin_req_in(s[20]),
    .serial_port_two_in(s[22:21]), .timer_twenty_one_req_in(s[23]),
    .external_irq_two_in(s[24]), .external_irq_zero_in(s[25]),
    .external_irq_one_in(s[26]), .wakeup_req_in(s[27]),
    .divider_req_in(s[28]), .charge_pump_req_in(s[29]),
    .bridge_driver_req_in(s[30]), .high_side_switch_req_in(s[31]),
    .current_sense_req_in(s[32]), .differential_unit_req_in(s[33]),
    .monitor_input_req_in(s[34]), .analog_port_req_in(s[35]),
    .vector_priority_in(prio), .nmi_sources_in(s[45:36]),
    .flash_fail_addr_in(addr), .vector_req_out(vec),
    .vector_priority_out(prio_o), .nmi_req_out(nmi),
    .flash_fail_addr_out(faddr), .flash_fail_valid_out(fvalid));
  core_irq_model u_core_irq_model (.sys_clk_in, .reset_in,
    .vector_req_in(vec), .nmi_req_in(nmi), .pending_out(pending),
    .nmi_seen_out(nmi_seen));
  function automatic logic [23:0] exp_vec(input logic [45:0] v);
    return {v[35:29], 1'b0, v[28:27], v[26], v[25] | v[27], |v[24:21],
      |v[20:16], |v[15:13], |v[12:10], v[9:6], v[5], |v[4:2], v[1:0]};
  endfunction
  // sparse draws, so shared lines also see single sources
  function automatic logic [45:0] rnd();
    logic [45:0] r;
    for (int i = 0; i < 46; i++) r[i] = ($random(seed) & 7) == 0;
    return r;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input logic [45:0] ns, input logic [63:0] r);
    @(negedge sys_clk_in);
    if (s[38]) begin
      e_addr = addr;
      e_valid = 1'b1;
    end
    chk(vec, exp_vec(s));
    chk(prio_o, prio);
    chk(nmi, |s[45:36]);
    chk({fvalid, faddr}, {e_valid, e_addr});
    s = ns;
    prio = r[47:0];
    addr = r[63:48];
  endtask
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (10) @(negedge sys_clk_in);
    reset_in = 1'b0;
    e_valid = 1'b0;
    e_addr = 16'h0000;
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    do_reset();
    step({46{1'b1}}, {64{1'b1}});
    step(46'h0, 64'h0);
    for (int i = 0; i < 46; i++) begin
      step(46'h1 << i, {$random(seed), $random(seed)});
    end
    for (int i = 0; i < 3000; i++) begin
      if (i == 1500) begin
        step(46'h0, 64'h0);
        do_reset();
      end
      step(rnd(), {$random(seed), $random(seed)});
    end
    step(46'h0, 64'h0);
    step(46'h0, 64'h0);
    chk(nmi_seen, 1'b1);
    repeat (24) step(46'h0, 64'h0);
    chk(pending, 24'h000000);
    report_and_stop();
  end
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule // interrupt_request_router_test
